/* pkg/tmsr_defines.svh */
// register offsets, field positions, reset values and counts of the temperature status block
`ifndef TMSR_DEFINES_SVH
`define TMSR_DEFINES_SVH
// read and write addresses
`define TMSR_A_LOCAL_VAL 8'h00
`define TMSR_A_REM_VAL_HI 8'h01
`define TMSR_A_STATUS 8'h02
`define TMSR_A_REM_VAL_LO 8'h10
`define TMSR_A_LHL_RD 8'h05
`define TMSR_A_LLL_RD 8'h06
`define TMSR_A_RHL_RD 8'h07
`define TMSR_A_RLL_RD 8'h08
`define TMSR_A_LHL_WR 8'h0B
`define TMSR_A_LLL_WR 8'h0C
`define TMSR_A_RHL_WR 8'h0D
`define TMSR_A_RLL_WR 8'h0E
`define TMSR_A_OFS_HI 8'h11
`define TMSR_A_OFS_LO 8'h12
`define TMSR_A_RHL_LO 8'h13
`define TMSR_A_RLL_LO 8'h14
`define TMSR_A_RSHUT 8'h19
`define TMSR_A_LSHUT 8'h20
`define TMSR_A_HYST 8'h21
`define TMSR_A_FQ_CTRL 8'h22
// limit bank slots
`define TMSR_SLOTS 11
`define TMSR_S_LHL 4'h0
`define TMSR_S_LLL 4'h1
`define TMSR_S_RHL 4'h2
`define TMSR_S_RLL 4'h3
`define TMSR_S_OFS_HI 4'h4
`define TMSR_S_OFS_LO 4'h5
`define TMSR_S_RHL_LO 4'h6
`define TMSR_S_RLL_LO 4'h7
`define TMSR_S_RSHUT 4'h8
`define TMSR_S_LSHUT 4'h9
`define TMSR_S_HYST 4'hA
// reset values
`define TMSR_RST_HI_LIM 8'h55
`define TMSR_RST_HYST 8'h0A
`define TMSR_RST_ZERO 8'h00
`define TMSR_RST_FQ_CTRL 8'h00
// status bit positions
`define TMSR_B_BUSY 7
`define TMSR_B_RSHUT 1
`define TMSR_B_LSHUT 0
`define TMSR_B_FLAG_LO 2
`define TMSR_NFLAGS 5
// fault queue control fields
`define TMSR_B_SCL_TO 7
`define TMSR_B_SDA_TO 6
`define TMSR_FQ_WMASK 8'hCF
`define TMSR_FQ_4 3'b111
`define TMSR_FQ_3 3'b011
`define TMSR_FQ_2 3'b001
`define TMSR_DEPTH_1 3'h1
`define TMSR_DEPTH_2 3'h2
`define TMSR_DEPTH_3 3'h3
`define TMSR_DEPTH_4 3'h4
`endif

/* pkg/tmsr_pkg.sv */
// types shared by the temperature status and limit register block
`include "tmsr_defines.svh"
package tmsr_pkg;
  // one finished measurement from the converter
  typedef struct packed {
    logic [7:0] local_val;
    logic [7:0] remote_hi;
    logic [7:0] remote_lo;
    logic remote_open;
  } tmsr_meas_t;
  // one register access from the bus engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmsr_req_t;
  typedef logic [`TMSR_SLOTS-1:0][7:0] tmsr_bank_t;
  typedef logic [3:0] tmsr_slot_t;
endpackage

/* rtl/tmsr_limit_bank.sv */
// limit, offset and hysteresis byte store with registered read port
`timescale 1ns/1ns
module tmsr_limit_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // write port
  input wire logic wr_en,
  input wire tmsr_pkg::tmsr_slot_t wr_slot,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire tmsr_pkg::tmsr_slot_t rd_slot,
  output logic [7:0] rd_data_q,
  // all bytes in parallel for the comparators
  output tmsr_pkg::tmsr_bank_t bank_q
);
  import tmsr_pkg::*;

  // power-on value of each slot
  function automatic logic [7:0] slot_rst(input int s);
    logic [7:0] v;
    v = `TMSR_RST_ZERO;
    if (s == int'(`TMSR_S_LHL) || s == int'(`TMSR_S_RHL)) begin
      v = `TMSR_RST_HI_LIM;
    end else if (s == int'(`TMSR_S_RSHUT) || s == int'(`TMSR_S_LSHUT)) begin
      v = `TMSR_RST_HI_LIM;
    end else if (s == int'(`TMSR_S_HYST)) begin
      v = `TMSR_RST_HYST;
    end
    return v;
  endfunction

  // one byte per slot
  for (genvar g = 0; g < `TMSR_SLOTS; g++) begin : g_slot
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        bank_q[g] <= slot_rst(g);
      end else if (wr_en && wr_slot == tmsr_slot_t'(g)) begin
        bank_q[g] <= wr_data;
      end
    end
  end

  // registered read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data_q <= `TMSR_RST_ZERO;
    end else if (rd_en) begin
      rd_data_q <= bank_q[rd_slot];
    end
  end
endmodule

/* rtl/tmsr_fault_cnt.sv */
// consecutive out-of-limit counter for one alert source
`timescale 1ns/1ns
module tmsr_fault_cnt (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // measurement result
  input wire logic meas_stb,
  input wire logic out_of_limit,
  input wire logic [2:0] depth,
  // qualified fault, one-cycle pulse
  output logic trip
);
  import tmsr_pkg::*;

  logic [2:0] cnt_q;

  // count runs, restart on any in-limit result
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= 3'h0;
    end else if (meas_stb) begin
      if (!out_of_limit) begin
        cnt_q <= 3'h0;
      end else if (cnt_q < depth) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // fires on every out-of-limit result once the run is long enough
  assign trip = meas_stb && out_of_limit && (cnt_q + 3'h1 >= depth);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  count_bound_a: assert property (cnt_q <= `TMSR_DEPTH_4)
    else $error("fault count above deepest queue");
  run_restart_a: assert property (meas_stb && !out_of_limit |=> cnt_q == 3'h0)
    else $error("fault count not restarted by in-limit result");
endmodule

/* rtl/tmsr_regs.sv */
// status, fault queue, value and limit registers of a dual-channel temperature monitor
`timescale 1ns/1ns
module tmsr_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register access from the bus engine
  input wire tmsr_pkg::tmsr_req_t req,
  output logic [7:0] reg_rdata,
  // converter side
  input wire logic conv_busy,
  input wire logic meas_stb,
  input wire tmsr_pkg::tmsr_meas_t meas,
  output logic [15:0] remote_offset,
  // configuration bits held elsewhere
  input wire logic alert_mask,
  input wire logic pin_is_alert,
  // outputs
  output logic alert_n,
  output logic thermal_shutdown_output_n,
  output logic scl_timeout_en,
  output logic sda_timeout_en
);
  import tmsr_pkg::*;

  tmsr_bank_t bank_q;
  logic [7:0] local_val_q;
  logic [7:0] remote_hi_q;
  logic [7:0] remote_lo_q;
  logic [7:0] fq_ctrl_q;
  logic [`TMSR_NFLAGS-1:0] flags_q;
  logic local_shutdown_flag_q;
  logic remote_shutdown_flag_q;
  logic [7:0] own_rdata_q;
  logic from_bank_q;
  logic [`TMSR_NFLAGS-1:0] oor;
  logic [`TMSR_NFLAGS-1:0] trip;
  logic [2:0] depth;
  logic rd_hit;
  logic wr_hit;
  tmsr_slot_t rd_slot;
  tmsr_slot_t wr_slot;
  logic status_rd;
  logic [15:0] remote_word;
  logic [15:0] remote_high_word;
  logic [15:0] remote_low_word;
  logic [7:0] local_release;
  logic [7:0] remote_release;
  logic [7:0] status_view;
  logic [7:0] bank_rdata;
  logic prev_ok_q;

  // read address to bank slot
  always_comb begin
    rd_hit = 1'b1;
    rd_slot = `TMSR_S_LHL;
    if (req.addr == `TMSR_A_LHL_RD) begin
      rd_slot = `TMSR_S_LHL;
    end else if (req.addr == `TMSR_A_LLL_RD) begin
      rd_slot = `TMSR_S_LLL;
    end else if (req.addr == `TMSR_A_RHL_RD) begin
      rd_slot = `TMSR_S_RHL;
    end else if (req.addr == `TMSR_A_RLL_RD) begin
      rd_slot = `TMSR_S_RLL;
    end else if (req.addr == `TMSR_A_OFS_HI) begin
      rd_slot = `TMSR_S_OFS_HI;
    end else if (req.addr == `TMSR_A_OFS_LO) begin
      rd_slot = `TMSR_S_OFS_LO;
    end else if (req.addr == `TMSR_A_RHL_LO) begin
      rd_slot = `TMSR_S_RHL_LO;
    end else if (req.addr == `TMSR_A_RLL_LO) begin
      rd_slot = `TMSR_S_RLL_LO;
    end else if (req.addr == `TMSR_A_RSHUT) begin
      rd_slot = `TMSR_S_RSHUT;
    end else if (req.addr == `TMSR_A_LSHUT) begin
      rd_slot = `TMSR_S_LSHUT;
    end else if (req.addr == `TMSR_A_HYST) begin
      rd_slot = `TMSR_S_HYST;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // write address to bank slot; read-only addresses miss
  always_comb begin
    wr_hit = 1'b1;
    wr_slot = `TMSR_S_LHL;
    if (req.addr == `TMSR_A_LHL_WR) begin
      wr_slot = `TMSR_S_LHL;
    end else if (req.addr == `TMSR_A_LLL_WR) begin
      wr_slot = `TMSR_S_LLL;
    end else if (req.addr == `TMSR_A_RHL_WR) begin
      wr_slot = `TMSR_S_RHL;
    end else if (req.addr == `TMSR_A_RLL_WR) begin
      wr_slot = `TMSR_S_RLL;
    end else if (req.addr == `TMSR_A_OFS_HI) begin
      wr_slot = `TMSR_S_OFS_HI;
    end else if (req.addr == `TMSR_A_OFS_LO) begin
      wr_slot = `TMSR_S_OFS_LO;
    end else if (req.addr == `TMSR_A_RHL_LO) begin
      wr_slot = `TMSR_S_RHL_LO;
    end else if (req.addr == `TMSR_A_RLL_LO) begin
      wr_slot = `TMSR_S_RLL_LO;
    end else if (req.addr == `TMSR_A_RSHUT) begin
      wr_slot = `TMSR_S_RSHUT;
    end else if (req.addr == `TMSR_A_LSHUT) begin
      wr_slot = `TMSR_S_LSHUT;
    end else if (req.addr == `TMSR_A_HYST) begin
      wr_slot = `TMSR_S_HYST;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // limit store
  tmsr_limit_bank u_bank (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(req.wr && wr_hit),
    .wr_slot(wr_slot),
    .wr_data(req.wdata),
    .rd_en(req.rd && rd_hit),
    .rd_slot(rd_slot),
    .rd_data_q(bank_rdata),
    .bank_q(bank_q)
  );

  // local over result of the previous strobe, for the queue check
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_ok_q <= 1'b1;
    end else if (meas_stb) begin
      prev_ok_q <= !oor[4];
    end
  end

  // measured values, read only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      local_val_q <= `TMSR_RST_ZERO;
      remote_hi_q <= `TMSR_RST_ZERO;
      remote_lo_q <= `TMSR_RST_ZERO;
    end else if (meas_stb) begin
      local_val_q <= meas.local_val;
      remote_hi_q <= meas.remote_hi;
      remote_lo_q <= meas.remote_lo;
    end
  end

  // fault queue and timeout control, reserved bits stay zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fq_ctrl_q <= `TMSR_RST_FQ_CTRL;
    end else if (req.wr && req.addr == `TMSR_A_FQ_CTRL) begin
      fq_ctrl_q <= req.wdata & `TMSR_FQ_WMASK;
    end
  end
  assign scl_timeout_en = fq_ctrl_q[`TMSR_B_SCL_TO];
  assign sda_timeout_en = fq_ctrl_q[`TMSR_B_SDA_TO];

  // queue depth from bits 3:1, bit 0 ignored
  always_comb begin
    if (fq_ctrl_q[3:1] == `TMSR_FQ_4) begin
      depth = `TMSR_DEPTH_4;
    end else if (fq_ctrl_q[3:1] == `TMSR_FQ_3) begin
      depth = `TMSR_DEPTH_3;
    end else if (fq_ctrl_q[3:1] == `TMSR_FQ_2) begin
      depth = `TMSR_DEPTH_2;
    end else begin
      depth = `TMSR_DEPTH_1;
    end
  end

  // limit comparisons on the fresh measurement
  assign remote_word = {meas.remote_hi, meas.remote_lo};
  assign remote_high_word = {bank_q[`TMSR_S_RHL], bank_q[`TMSR_S_RHL_LO]};
  assign remote_low_word = {bank_q[`TMSR_S_RLL], bank_q[`TMSR_S_RLL_LO]};
  assign oor[4] = meas.local_val > bank_q[`TMSR_S_LHL];
  assign oor[3] = meas.local_val < bank_q[`TMSR_S_LLL];
  assign oor[2] = !meas.remote_open && remote_word > remote_high_word;
  assign oor[1] = !meas.remote_open && remote_word < remote_low_word;
  assign oor[0] = meas.remote_open;
  assign remote_offset = {bank_q[`TMSR_S_OFS_HI], bank_q[`TMSR_S_OFS_LO]};

  // one consecutive counter per alerting source
  for (genvar i = 0; i < `TMSR_NFLAGS; i++) begin : g_src
    tmsr_fault_cnt u_cnt (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .meas_stb(meas_stb),
      .out_of_limit(oor[i]),
      .depth(depth),
      .trip(trip[i])
    );
  end

  // sticky flags; a trip in the clearing cycle wins
  // a read returns the flags held before its edge, so such a trip shows on the next read
  assign status_rd = req.rd && req.addr == `TMSR_A_STATUS;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else if (status_rd) begin
      flags_q <= trip;
    end else begin
      flags_q <= flags_q | trip;
    end
  end

  // shutdown comparators with hysteresis, live status
  // release point wraps if hysteresis exceeds the limit, so keep hysteresis below it
  assign local_release = bank_q[`TMSR_S_LSHUT] - bank_q[`TMSR_S_HYST];
  assign remote_release = bank_q[`TMSR_S_RSHUT] - bank_q[`TMSR_S_HYST];
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      local_shutdown_flag_q <= 1'b0;
    end else if (meas_stb && meas.local_val > bank_q[`TMSR_S_LSHUT]) begin
      local_shutdown_flag_q <= 1'b1;
    end else if (meas_stb && meas.local_val <= local_release) begin
      local_shutdown_flag_q <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      remote_shutdown_flag_q <= 1'b0;
    end else if (meas_stb && meas.remote_hi > bank_q[`TMSR_S_RSHUT]) begin
      remote_shutdown_flag_q <= 1'b1;
    end else if (meas_stb && meas.remote_hi <= remote_release) begin
      remote_shutdown_flag_q <= 1'b0;
    end
  end
  assign thermal_shutdown_output_n = !(local_shutdown_flag_q || remote_shutdown_flag_q);

  // alert from sticky flags only, masked by configuration
  assign alert_n = !(|flags_q && !(alert_mask && pin_is_alert));

  // status as seen by a read
  assign status_view = {conv_busy, flags_q, remote_shutdown_flag_q, local_shutdown_flag_q};

  // registered read data for addresses outside the bank
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      own_rdata_q <= `TMSR_RST_ZERO;
      from_bank_q <= 1'b0;
    end else if (req.rd) begin
      from_bank_q <= rd_hit;
      if (req.addr == `TMSR_A_STATUS) begin
        own_rdata_q <= status_view;
      end else if (req.addr == `TMSR_A_LOCAL_VAL) begin
        own_rdata_q <= local_val_q;
      end else if (req.addr == `TMSR_A_REM_VAL_HI) begin
        own_rdata_q <= remote_hi_q;
      end else if (req.addr == `TMSR_A_REM_VAL_LO) begin
        own_rdata_q <= remote_lo_q;
      end else if (req.addr == `TMSR_A_FQ_CTRL) begin
        own_rdata_q <= fq_ctrl_q;
      end else begin
        own_rdata_q <= `TMSR_RST_ZERO;
      end
    end
  end
  // limit bytes come from the bank's own registered read port
  assign reg_rdata = from_bank_q ? bank_rdata : own_rdata_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  busy_read_a: assert property (status_rd |=> reg_rdata[`TMSR_B_BUSY] == $past(conv_busy))
    else $error("busy bit not returned by status read");
  local_over_a: assert property (meas_stb && oor[4] && depth == `TMSR_DEPTH_1 |=> flags_q[4])
    else $error("local over flag not set");
  local_under_a: assert property (meas_stb && oor[3] && depth == `TMSR_DEPTH_1 |=> flags_q[3])
    else $error("local under flag not set");
  remote_over_a: assert property (meas_stb && oor[2] && depth == `TMSR_DEPTH_1 |=> flags_q[2])
    else $error("remote over flag not set");
  remote_under_a: assert property (meas_stb && oor[1] && depth == `TMSR_DEPTH_1 |=> flags_q[1])
    else $error("remote under flag not set");
  open_flag_a: assert property (meas_stb && meas.remote_open && depth == `TMSR_DEPTH_1 |=> flags_q[0])
    else $error("open sensor flag not set");
  flag_hold_a: assert property (!status_rd |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("sticky flag dropped without status read");
  read_clear_a: assert property (status_rd && trip == '0 |=> flags_q == '0)
    else $error("status read did not clear flags");
  shutdown_quiet_a: assert property (flags_q == '0 |-> alert_n)
    else $error("alert without an alerting flag");
  mask_gate_a: assert property (alert_mask && pin_is_alert |-> alert_n)
    else $error("alert not suppressed by mask");
  // fault queue register
  scl_enable_a: assert property (req.wr && req.addr == `TMSR_A_FQ_CTRL
    |=> scl_timeout_en == $past(req.wdata[`TMSR_B_SCL_TO]))
    else $error("clock timeout enable not written");
  sda_enable_a: assert property (req.wr && req.addr == `TMSR_A_FQ_CTRL
    |=> sda_timeout_en == $past(req.wdata[`TMSR_B_SDA_TO]))
    else $error("data timeout enable not written");
  queue_two_a: assert property (depth == `TMSR_DEPTH_2 && prev_ok_q && !flags_q[4] && !status_rd
    && meas_stb && oor[4] |=> !flags_q[4])
    else $error("flag set before two consecutive faults");
  // read-only values and limit bytes
  value_ro_a: assert property (req.wr && !meas_stb && req.addr == `TMSR_A_LOCAL_VAL
    |=> local_val_q == $past(local_val_q))
    else $error("read-only value changed by a write");
  remote_ro_a: assert property (req.wr && !meas_stb && req.addr == `TMSR_A_REM_VAL_LO
    |=> remote_lo_q == $past(remote_lo_q))
    else $error("read-only remote value changed by a write");
  limit_write_a: assert property (req.wr && req.addr == `TMSR_A_LHL_WR ##1 !req.wr
    ##1 req.rd && req.addr == `TMSR_A_LHL_RD |=> reg_rdata == $past(req.wdata, 3))
    else $error("local high limit write not read back");
  bank_read_a: assert property (req.rd && rd_hit |=> reg_rdata == $past(bank_q[rd_slot]))
    else $error("limit byte not returned by read");
  // shutdown flags
  local_shut_a: assert property (meas_stb && meas.local_val > bank_q[`TMSR_S_LSHUT]
    |=> local_shutdown_flag_q && !thermal_shutdown_output_n)
    else $error("local shutdown flag not set");
  remote_shut_a: assert property (meas_stb && meas.remote_hi > bank_q[`TMSR_S_RSHUT]
    |=> remote_shutdown_flag_q && !thermal_shutdown_output_n)
    else $error("remote shutdown flag not set");
  shut_status_a: assert property (status_rd
    |=> reg_rdata[`TMSR_B_RSHUT] == $past(remote_shutdown_flag_q)
    && reg_rdata[`TMSR_B_LSHUT] == $past(local_shutdown_flag_q))
    else $error("shutdown bits not returned by status read");

  alert_seen_c: cover property (!alert_n);
  queue_two_c: cover property (depth == `TMSR_DEPTH_2 && trip[4]);
  read_clear_c: cover property (status_rd && flags_q != '0);
  queue_four_c: cover property (depth == `TMSR_DEPTH_4 && trip[4]);
  shutdown_c: cover property (!thermal_shutdown_output_n);
endmodule

/* testbench/tmsr_host_model.sv */
// register host model driving the access port of the status and limit block
`timescale 1ns/1ns
module tmsr_host_model (
  // clock
  input wire logic mclk,
  // access port
  output tmsr_pkg::tmsr_req_t req,
  input wire logic [7:0] reg_rdata
);
  import tmsr_pkg::*;
  // idle bus at start
  initial begin
    req = '0;
  end
  // one write, held for exactly the taking edge, then scrambled address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // one read, data taken the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    @(posedge mclk);
    d = reg_rdata;
  endtask
endmodule

/* testbench/tmsr_regs_tb_top.sv */
// self-checking bench for the temperature status and limit register block
`timescale 1ns/1ns
module tmsr_regs_tb_top;
  import tmsr_pkg::*;
  logic mclk, sys_rst, conv_busy, meas_stb, alert_mask, pin_is_alert;
  logic alert_n, thermal_shutdown_output_n, scl_timeout_en, sda_timeout_en;
  tmsr_req_t req;
  tmsr_meas_t meas;
  logic [7:0] reg_rdata, d, l, c;
  logic [15:0] remote_offset, r;
  logic [7:0] wd [11];
  logic op, b;
  integer seed, n_mismatch, num_checks;
  // reset values by read address, then an unmapped address
  localparam logic [15:0] RST_TAB [17] = '{16'h0000, 16'h0100, 16'h1000, 16'h0200, 16'h0555, 16'h0600,
    16'h0755, 16'h0800, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h1955, 16'h2055, 16'h210A, 16'h2200,
    16'h0300};
  // write address, read address and working value of each writable limit bank byte
  localparam logic [23:0] RW_TAB [11] = '{24'h0B0540, 24'h0C0620, 24'h0D0740, 24'h0E0820, 24'h111100,
    24'h121200, 24'h131380, 24'h141400, 24'h191955, 24'h202055, 24'h21210A};
  localparam logic [7:0] FQ_TAB [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0E, 8'h0F};

  tmsr_regs dut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .reg_rdata(reg_rdata), .conv_busy(conv_busy),
    .meas_stb(meas_stb), .meas(meas), .remote_offset(remote_offset), .alert_mask(alert_mask),
    .pin_is_alert(pin_is_alert), .alert_n(alert_n), .thermal_shutdown_output_n(thermal_shutdown_output_n),
    .scl_timeout_en(scl_timeout_en), .sda_timeout_en(sda_timeout_en));
  tmsr_host_model host (.mclk(mclk), .req(req), .reg_rdata(reg_rdata));

  // clock
  always #2 mclk = ~mclk;

  // status expected for the working limits: local 0x20..0x40, remote 0x2000..0x4080
  function automatic logic [7:0] exp_status(logic bz, logic [7:0] lv, logic [15:0] rv, logic opn);
    return {bz, lv > 8'h40, lv < 8'h20, !opn && rv > 16'h4080, !opn && rv < 16'h2000, opn, 2'b00};
  endfunction
  // consecutive results needed for a fault queue code
  function automatic int depth_of(logic [7:0] cd);
    case (cd[3:1])
      3'b111: return 4;
      3'b011: return 3;
      3'b001: return 2;
      default: return 1;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one finished measurement, flags looked at once the taking edge has landed
  task automatic meas_go(input logic [7:0] lv, input logic [15:0] rv, input logic opn);
    @(posedge mclk);
    meas <= '{local_val: lv, remote_hi: rv[15:8], remote_lo: rv[7:0], remote_open: opn};
    meas_stb <= 1'b1;
    @(posedge mclk);
    meas_stb <= 1'b0;
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #40000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    mclk = 0; sys_rst = 1; conv_busy = 0; meas_stb = 0; meas = '0; alert_mask = 0; pin_is_alert = 0;
    seed = 32'hF353; n_mismatch = 0; num_checks = 0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values and idle outputs
    foreach (RST_TAB[i]) begin
      host.rd(RST_TAB[i][15:8], d);
      chk("reset value", RST_TAB[i][7:0], d);
    end
    chk("timeouts", 8'h00, {6'h00, scl_timeout_en, sda_timeout_en});
    chk("alert_n", 8'h01, {7'h00, alert_n});
    $display("test reset values done");
    // random then working values through write address, read back at read address
    for (int p = 0; p < 2; p++) begin
      foreach (RW_TAB[i]) begin
        wd[i] = p ? RW_TAB[i][7:0] : 8'($random(seed));
        host.wr(RW_TAB[i][23:16], wd[i]);
      end
      foreach (RW_TAB[i]) begin
        host.rd(RW_TAB[i][15:8], d);
        chk("limit readback", wd[i], d);
      end
      chk("offset high", wd[4], remote_offset[15:8]);
      chk("offset low", wd[5], remote_offset[7:0]);
    end
    host.wr(8'h00, 8'($random(seed)));
    host.rd(8'h00, d);
    chk("local value write", 8'h00, d);
    $display("test limit registers done");
    // timeout enables and reserved bits of the fault queue register
    foreach (FQ_TAB[i]) begin
      c = FQ_TAB[i] | {i[1], i[0], 6'h30};
      host.wr(8'h22, c);
      host.rd(8'h22, d);
      chk("fault queue ctrl", c & 8'hCF, d);
      chk("timeouts", {6'h00, c[7:6]}, {6'h00, scl_timeout_en, sda_timeout_en});
    end
    host.wr(8'h22, 8'h00);
    $display("test fault queue register done");
    // random measurements at depth 1, with busy, mask and pin function drawn at random
    repeat (40) begin
      l = 8'($random(seed) & 32'h3F) + 8'h10;
      r = {8'($random(seed) & 32'h3F) + 8'h10, 8'($random(seed))};
      op = ($random(seed) & 3) == 0;
      b = 1'($random(seed));
      @(posedge mclk);
      conv_busy <= b;
      alert_mask <= 1'($random(seed));
      pin_is_alert <= 1'($random(seed));
      meas_go(l, r, op);
      c = exp_status(b, l, r, op);
      chk("alert_n", {7'h00, !(|c[6:2] && !(alert_mask && pin_is_alert))}, {7'h00, alert_n});
      host.rd(8'h02, d);
      chk("status", c, d);
      host.rd(8'h02, d);
      chk("status cleared", {b, 7'h00}, d);
    end
    conv_busy <= 1'b0;
    alert_mask <= 1'b0;
    pin_is_alert <= 1'b0;
    $display("test random measurements done");
    // consecutive runs per queue code, broken by an in-limit result
    foreach (FQ_TAB[i]) begin
      host.wr(8'h22, FQ_TAB[i]);
      meas_go(8'h30, 16'h3000, 1'b0);
      host.rd(8'h02, d);
      repeat (depth_of(FQ_TAB[i]) - 1) meas_go(8'h50, 16'h3000, 1'b0);
      meas_go(8'h30, 16'h3000, 1'b0);
      repeat (depth_of(FQ_TAB[i]) - 1) meas_go(8'h50, 16'h3000, 1'b0);
      chk("alert_n short run", 8'h01, {7'h00, alert_n});
      meas_go(8'h50, 16'h3000, 1'b0);
      chk("alert_n full run", 8'h00, {7'h00, alert_n});
      meas_go(8'h30, 16'h3000, 1'b0);
      chk("alert_n latched", 8'h00, {7'h00, alert_n});
      host.rd(8'h02, d);
      chk("status latched", 8'h40, d);
    end
    host.wr(8'h22, 8'h00);
    $display("test fault queue depth done");
    // shutdown flags with high limits out of reach, then hysteresis release
    host.wr(8'h0B, 8'hFF);
    host.rd(8'h05, d);
    chk("local high limit", 8'hFF, d);
    host.wr(8'h0D, 8'hFF);
    meas_go(8'h60, 16'h6040, 1'b0);
    chk("alert_n shutdown", 8'h01, {7'h00, alert_n});
    chk("shutdown out", 8'h00, {7'h00, thermal_shutdown_output_n});
    host.rd(8'h02, d);
    chk("status shutdown", 8'h03, d);
    host.rd(8'h00, d);
    chk("local value", 8'h60, d);
    host.rd(8'h01, d);
    chk("remote value high", 8'h60, d);
    host.wr(8'h10, 8'hFF);
    host.rd(8'h10, d);
    chk("remote value low", 8'h40, d);
    meas_go(8'h50, 16'h5000, 1'b0);
    host.rd(8'h02, d);
    chk("status in hysteresis", 8'h03, d);
    meas_go(8'h4B, 16'h4B40, 1'b0);
    host.rd(8'h02, d);
    chk("status released", 8'h00, d);
    chk("shutdown out", 8'h01, {7'h00, thermal_shutdown_output_n});
    $display("test shutdown flags done");
    finish_test;
  end
endmodule
